// ---- src/dcc_flow_top.sv ----
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Non-blocking mode keeps latched rx/tx full flags as the debugger saw them.
// - Core read of rx clears live full; latched copy stays set.
// - Non-blocking: debugger rx writes ignored while latched rx full is set.
// - Non-blocking: latched rx full updated on status read and on debugger rx write.
// - Non-blocking: latched tx full updated on status read and on debugger tx read.
// - While discard set, async aborts only set the sticky abort flag and the abort interrupt status bit.
// - All outstanding async aborts are recognised before halt is entered.
// - Discard bit is set right on entry to debug halt.
// - Outside halt, debug-ack never sets discard; aborts pend normally.
// - Channel access mode resets to non-blocking encoding.
// - Writing zero to status/control returns all fields except halted and discard to reset values.
module dcc_flow_top (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  // Avalon-MM slave (debugger side)
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Core side
  input  wire logic        i_core_rx_read,
  output logic [31:0]      o_core_rx_data,
  input  wire logic        i_core_tx_write,
  input  wire logic [31:0] i_core_tx_data,
  output logic             o_core_rx_full,
  output logic             o_core_tx_full,
  // Halt and abort handling
  input  wire logic        i_halt_req,
  input  wire logic        i_resume_req,
  input  wire logic        i_abort_outstanding,
  input  wire logic        i_async_abort,
  output logic             o_abort_to_core,
  output logic             o_halted,
  output logic             o_irq
);
  import dcc_pkg::*;

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  // Each access is answered one cycle after it is presented.
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        rd_ev;
  logic        wr_ev;
  assign acc   = (i_avs_read || i_avs_write) && !ack_q;
  assign rd_ev = i_ce && acc && i_avs_read;
  assign wr_ev = i_ce && acc && i_avs_write;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_ce) begin
      o_avs_waitrequest <= !acc;
    end
  end

  // ------------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------------
  logic [1:0]          mode_q;
  logic                dbg_ack_q;
  logic                discard_q;
  logic                abort_sticky_q;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic [31:0]         rx_data_q;
  logic [31:0]         tx_data_q;
  halt_state_t         halt_q;
  logic                sc_wr;
  logic                sc_zero;
  logic                sc_rd;
  logic                rx_wr;
  logic                tx_rd;
  logic                rx_blocked;
  logic                rx_live;
  logic                rx_lat;
  logic                tx_live;
  logic                tx_lat;
  logic                nb_mode;

  assign sc_wr   = wr_ev && (i_avs_address == OFF_STATUS_CTRL);
  assign sc_zero = sc_wr && (i_avs_writedata == ZERO_WORD);
  assign sc_rd   = rd_ev && (i_avs_address == OFF_STATUS_CTRL);
  assign rx_wr   = wr_ev && (i_avs_address == OFF_RX_XFER);
  assign tx_rd   = rd_ev && (i_avs_address == OFF_TX_XFER);
  assign nb_mode = (mode_q == MODE_NON_BLOCKING);
  assign rx_blocked = nb_mode ? rx_lat : rx_live;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q    <= MODE_RESET;
      dbg_ack_q <= 1'b0;
    end else if (i_ce && sc_wr) begin
      mode_q    <= i_avs_writedata[BIT_MODE_HI:BIT_MODE_LO];
      dbg_ack_q <= i_avs_writedata[BIT_DEBUG_ACK];
    end
  end

  // ------------------------------------------------------------------
  // Transfer registers
  // ------------------------------------------------------------------
  full_flag u_rx_flag (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_set       (rx_wr && !rx_blocked),
    .i_clr       (i_core_rx_read),
    .i_latch     (nb_mode && (sc_rd || rx_wr)),
    .i_force_clr (sc_zero),
    .o_live      (rx_live),
    .o_latched   (rx_lat)
  );

  full_flag u_tx_flag (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_set       (i_core_tx_write),
    .i_clr       (tx_rd),
    .i_latch     (nb_mode && (sc_rd || tx_rd)),
    .i_force_clr (sc_zero),
    .o_live      (tx_live),
    .o_latched   (tx_lat)
  );

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_data_q <= ZERO_WORD;
    end else if (i_ce && rx_wr && !rx_blocked) begin
      rx_data_q <= i_avs_writedata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_data_q <= ZERO_WORD;
    end else if (i_ce && i_core_tx_write) begin
      tx_data_q <= i_core_tx_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_rx_data <= ZERO_WORD;
      o_core_rx_full <= 1'b0;
      o_core_tx_full <= 1'b0;
    end else if (i_ce) begin
      if (i_core_rx_read) begin
        o_core_rx_data <= rx_data_q;
      end
      o_core_rx_full <= rx_live;
      o_core_tx_full <= tx_live;
    end
  end

  // ------------------------------------------------------------------
  // Debug halt and abort discard
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      halt_q <= HALT_RUN;
    end else if (i_ce) begin
      case (halt_q)
        HALT_RUN: begin
          if (i_halt_req) begin
            halt_q <= HALT_DRAIN;
          end
        end
        HALT_DRAIN: begin
          if (!i_abort_outstanding && !i_async_abort) begin
            halt_q <= HALT_IN;
          end
        end
        HALT_IN: begin
          if (i_resume_req) begin
            halt_q <= HALT_RUN;
          end
        end
        default: begin
          halt_q <= HALT_RUN;
        end
      endcase
    end
  end

  // Discard follows halt state only; debug-ack has no say
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      discard_q <= 1'b0;
    end else if (i_ce) begin
      discard_q <= (halt_q == HALT_DRAIN) && !i_abort_outstanding
                   && !i_async_abort || (halt_q == HALT_IN)
                   && !i_resume_req;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      abort_sticky_q <= 1'b0;
    end else if (i_ce) begin
      if (i_async_abort && discard_q) begin
        abort_sticky_q <= 1'b1;
      end else if (sc_zero) begin
        abort_sticky_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_abort_to_core <= 1'b0;
      o_halted        <= 1'b0;
    end else if (i_ce) begin
      o_abort_to_core <= i_async_abort && !discard_q;
      o_halted        <= (halt_q == HALT_IN);
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [IRQ_BITS-1:0] irq_ev;
  assign irq_ev[IRQ_RX_DRAINED] = i_core_rx_read && rx_live;
  assign irq_ev[IRQ_TX_FILLED]  = i_core_tx_write;
  assign irq_ev[IRQ_ABORT]      = i_async_abort && discard_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_q <= IRQ_RESET;
    end else if (i_ce) begin
      if (wr_ev && i_avs_address == OFF_IRQ_STATUS) begin
        irq_stat_q <= (irq_stat_q & ~i_avs_writedata[IRQ_BITS-1:0])
                      | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask_q <= IRQ_RESET;
    end else if (i_ce && wr_ev && i_avs_address == OFF_IRQ_MASK) begin
      irq_mask_q <= i_avs_writedata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] sc_word;
  always_comb begin
    sc_word = ZERO_WORD;
    sc_word[BIT_RX_FULL_LIVE]    = rx_live;
    sc_word[BIT_TX_FULL_LIVE]    = tx_live;
    sc_word[BIT_RX_FULL_LATCHED] = rx_lat;
    sc_word[BIT_TX_FULL_LATCHED] = tx_lat;
    sc_word[BIT_ABORT_DISCARD]   = discard_q;
    sc_word[BIT_ASYNC_ABORT]     = abort_sticky_q;
    sc_word[BIT_DEBUG_ACK]       = dbg_ack_q;
    sc_word[BIT_HALTED]          = (halt_q == HALT_IN);
    sc_word[BIT_MODE_HI:BIT_MODE_LO] = mode_q;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= ZERO_WORD;
    end else if (rd_ev) begin
      case (i_avs_address)
        OFF_STATUS_CTRL: rdata_q <= sc_word;
        OFF_TX_XFER:     rdata_q <= tx_data_q;
        OFF_IRQ_STATUS:  rdata_q <= {{(32-IRQ_BITS){1'b0}}, irq_stat_q};
        OFF_IRQ_MASK:    rdata_q <= {{(32-IRQ_BITS){1'b0}}, irq_mask_q};
        default:         rdata_q <= ZERO_WORD;
      endcase
    end
  end

  assign o_avs_readdata = rdata_q;
endmodule : dcc_flow_top

// ---- src/dcc_pkg.sv ----
package dcc_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [4:0] OFF_STATUS_CTRL = 5'h00;
  localparam logic [4:0] OFF_RX_XFER     = 5'h04;
  localparam logic [4:0] OFF_TX_XFER     = 5'h08;
  localparam logic [4:0] OFF_IRQ_STATUS  = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK    = 5'h10;
  // Status/control field positions
  localparam int BIT_RX_FULL_LIVE    = 0;
  localparam int BIT_TX_FULL_LIVE    = 1;
  localparam int BIT_RX_FULL_LATCHED = 2;
  localparam int BIT_TX_FULL_LATCHED = 3;
  localparam int BIT_ABORT_DISCARD   = 4;
  localparam int BIT_ASYNC_ABORT     = 5;
  localparam int BIT_DEBUG_ACK       = 6;
  localparam int BIT_HALTED          = 7;
  localparam int BIT_MODE_LO         = 8;
  localparam int BIT_MODE_HI         = 9;
  // Channel access modes
  localparam logic [1:0] MODE_NON_BLOCKING = 2'h0;
  localparam logic [1:0] MODE_RESET        = MODE_NON_BLOCKING;
  // Interrupt event bits
  localparam int IRQ_BITS       = 3;
  localparam int IRQ_RX_DRAINED = 0;
  localparam int IRQ_TX_FILLED  = 1;
  localparam int IRQ_ABORT      = 2;
  localparam logic [IRQ_BITS-1:0] IRQ_RESET = 3'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {HALT_RUN, HALT_DRAIN, HALT_IN} halt_state_t;
endpackage : dcc_pkg

// ---- src/full_flag.sv ----
`timescale 1ns/1ps
module full_flag (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_clr,
  input  wire logic i_latch,
  input  wire logic i_force_clr,
  output logic      o_live,
  output logic      o_latched
);
  logic live_d;
  // Next live flag: set by producer, cleared by consumer; set wins
  always_comb begin
    live_d = o_live;
    if (i_set) begin
      live_d = 1'b1;
    end else if (i_clr || i_force_clr) begin
      live_d = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_live <= 1'b0;
    end else if (i_ce) begin
      o_live <= live_d;
    end
  end
  // Latched copy takes the flag as left by this access, so a taken
  // rx write blocks the next one until status is read again
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_latched <= 1'b0;
    end else if (i_ce) begin
      if (i_force_clr) begin
        o_latched <= 1'b0;
      end else if (i_latch) begin
        o_latched <= live_d;
      end
    end
  end
endmodule : full_flag

// ---- dv/dcc_flow_props.sv ----
`timescale 1ns/1ps
module dcc_flow_props (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_ce,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_core_rx_read,
  input wire logic        i_core_tx_write,
  input wire logic        o_core_rx_full,
  input wire logic        o_core_tx_full,
  input wire logic        i_abort_outstanding,
  input wire logic        i_async_abort,
  input wire logic        o_abort_to_core,
  input wire logic        o_halted
);
  import dcc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || !i_ce);
  // --------------------------------------------------
  // Bus handshake and channel flags
  // --------------------------------------------------
  ack_next_cycle_a: assert property (
    $rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
    else $error("ack not one cycle after request");
  ack_single_a: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("ack longer than one cycle");
  rx_drain_clears_a: assert property (
    i_core_rx_read && !i_avs_write |=> ##1 !o_core_rx_full)
    else $error("rx full kept after core read");
  tx_fill_sets_a: assert property (
    i_core_tx_write |=> ##1 o_core_tx_full)
    else $error("tx full not set by core write");
  // --------------------------------------------------
  // Halt and abort discard
  // --------------------------------------------------
  discard_tracks_halt_a: assert property (
    !o_avs_waitrequest && $past(i_avs_read)
    && $past(i_avs_address) == OFF_STATUS_CTRL
    |-> o_avs_readdata[BIT_ABORT_DISCARD] == o_avs_readdata[BIT_HALTED])
    else $error("discard bit differs from halt state");
  abort_dropped_a: assert property (
    o_halted && i_async_abort |=> (!o_abort_to_core || !o_halted))
    else $error("abort passed while halted");
  abort_passed_a: assert property (
    !o_halted && i_async_abort |=> (o_abort_to_core || o_halted))
    else $error("abort lost while running");
  halt_after_drain_a: assert property (
    $rose(o_halted) |-> !$past(i_abort_outstanding, 2)
    && !$past(i_async_abort, 2))
    else $error("halt entered with abort in flight");
endmodule : dcc_flow_props

bind dcc_flow_top dcc_flow_props u_props (.*);

// ---- dv/dbg_model.sv ----
`timescale 1ns/1ps
module dbg_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_readdata,
  input  wire logic        i_waitrequest,
  output logic [4:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata
);
  import dcc_pkg::*;
  initial begin
    o_address = 5'h1F;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
  end
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    o_address <= a;
    o_writedata <= wd;
    o_read <= !w;
    o_write <= w;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0) @(posedge i_clk);
    rd = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released lines show no stale value
    o_address <= ~a;
    o_writedata <= ~wd;
  endtask : access
  task automatic init_after_reset();
    logic [31:0] d;
    access(1'b1, OFF_STATUS_CTRL, ZERO_WORD, d);
  endtask : init_after_reset
  task automatic send_rx(input logic [31:0] wd, output logic ok);
    logic [31:0] st;
    access(1'b0, OFF_STATUS_CTRL, ZERO_WORD, st);
    ok = !st[BIT_RX_FULL_LIVE];
    if (ok) access(1'b1, OFF_RX_XFER, wd, st);
  endtask : send_rx
  task automatic leave_check(output logic sticky);
    logic [31:0] st;
    access(1'b0, OFF_STATUS_CTRL, ZERO_WORD, st);
    sticky = st[BIT_ASYNC_ABORT];
  endtask : leave_check
endmodule : dbg_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import dcc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        ce = 1'b1;
  logic [4:0]  adr;
  logic        rd, wr, wreq, crd, cwr, hreq, resm, outst, abrt, ok;
  logic        rxf, txf, a2c, hlt, irq;
  logic [31:0] wdat, rdat, crx, ctx, got, d;
  logic [31:0] rxq[$];
  int          n_errors = 0;
  int          n_tests = 0;
  int          lat;
  always #25 i_clk = ~i_clk;
  dcc_flow_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_core_rx_read(crd), .o_core_rx_data(crx),
    .i_core_tx_write(cwr), .i_core_tx_data(ctx), .o_core_rx_full(rxf),
    .o_core_tx_full(txf), .i_halt_req(hreq), .i_resume_req(resm),
    .i_abort_outstanding(outst), .i_async_abort(abrt),
    .o_abort_to_core(a2c), .o_halted(hlt), .o_irq(irq));
  dbg_model u_dbg (.i_clk(i_clk), .i_readdata(rdat), .i_waitrequest(wreq),
    .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wdat));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic stat();
    u_dbg.access(1'b0, OFF_STATUS_CTRL, ZERO_WORD, got);
    lat = got[BIT_RX_FULL_LIVE];
  endtask : stat
  task automatic rx_wr(input logic [31:0] v);
    u_dbg.access(1'b1, OFF_RX_XFER, v, got);
    if (lat == 0) rxq.push_back(v);
    lat = 1;
  endtask : rx_wr
  task automatic core_rd();
    @(posedge i_clk) crd <= 1'b1;
    @(posedge i_clk) crd <= 1'b0;
    @(posedge i_clk);
    chk(crx, rxq.pop_front());
  endtask : core_rd
  task automatic pulse(input bit res);
    @(posedge i_clk);
    if (res) resm <= 1'b1;
    else abrt <= 1'b1;
    @(posedge i_clk);
    {resm, abrt} <= 2'h0;
    repeat (2) @(posedge i_clk);
  endtask : pulse
  initial begin
    #300000;
    n_errors++;
    summarize();
  end
  initial begin
    {crd, cwr, hreq, resm, outst, abrt} = 6'h00;
    ctx = 32'h0;
    void'($urandom(38));
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    u_dbg.init_after_reset();
    stat();
    chk(got, ZERO_WORD);
    u_dbg.access(1'b1, OFF_STATUS_CTRL, 32'h0000_0340, got);
    stat();
    chk(got & 32'h0000_03C0, 32'h0000_0340);
    u_dbg.access(1'b1, OFF_STATUS_CTRL, ZERO_WORD, got);
    stat();
    chk(got, ZERO_WORD);
    $display("test reset done");
    repeat (2) rx_wr($urandom());
    core_rd();
    rx_wr($urandom());
    stat();
    chk(got & 32'h1, 32'h0);
    d = $urandom();
    u_dbg.send_rx(d, ok);
    chk(ok, 1'b1);
    rxq.push_back(d);
    core_rd();
    $display("test rx done");
    repeat (2) begin
      d = $urandom();
      @(posedge i_clk) begin
        cwr <= 1'b1;
        ctx <= d;
      end
      @(posedge i_clk) cwr <= 1'b0;
      stat();
      chk(got & 32'h2, 32'h2);
      u_dbg.access(1'b0, OFF_TX_XFER, ZERO_WORD, got);
      chk(got, d);
      stat();
      chk(got & 32'hA, 32'h0);
    end
    @(posedge i_clk) begin
      ce <= 1'b0;
      cwr <= 1'b1;
    end
    @(posedge i_clk) cwr <= 1'b0;
    @(posedge i_clk) ce <= 1'b1;
    stat();
    chk(got & 32'h2, 32'h0);
    $display("test tx done");
    u_dbg.access(1'b1, OFF_IRQ_STATUS, 32'h7, got);
    u_dbg.access(1'b1, OFF_STATUS_CTRL, 32'h40, got);
    pulse(1'b0);
    stat();
    chk(got & 32'hB0, 32'h0);
    chk(irq, 1'b0);
    u_dbg.access(1'b0, OFF_IRQ_STATUS, ZERO_WORD, got);
    chk(got, ZERO_WORD);
    @(posedge i_clk) {outst, hreq} <= 2'h3;
    repeat (4) @(posedge i_clk);
    chk(hlt, 1'b0);
    outst <= 1'b0;
    for (int i = 0; i < 20 && hlt !== 1'b1; i++) @(posedge i_clk);
    hreq <= 1'b0;
    stat();
    chk(got & 32'hB0, 32'h90);
    pulse(1'b0);
    chk(irq, 1'b0);
    u_dbg.access(1'b0, OFF_IRQ_STATUS, ZERO_WORD, got);
    chk(got, 32'h4);
    u_dbg.access(1'b1, OFF_IRQ_MASK, 32'h4, got);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b1);
    u_dbg.leave_check(ok);
    chk(ok, 1'b1);
    u_dbg.access(1'b1, OFF_IRQ_STATUS, 32'h4, got);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b0);
    pulse(1'b1);
    stat();
    chk(got & 32'h90, 32'h0);
    $display("test halt done");
    summarize();
  end
endmodule : tb_top
